// ---- rtl/duc_pkg.sv ----
// constants for the dac update control block
// assumes a 32-bit msb-first frame on the serial link
package duc_pkg;
  // ****************************************
  // frame layout
  // ****************************************
  localparam int unsigned FRAME_BITS = 32;
  localparam logic [5:0] LAST_BIT = 6'h1F;
  localparam int unsigned CMD_HI = 27;
  localparam int unsigned CMD_LO = 24;
  localparam int unsigned ADDR_HI = 23;
  localparam int unsigned ADDR_LO = 20;
  localparam int unsigned DATA_HI = 19;
  localparam int unsigned DATA_LO = 8;
  localparam int unsigned PD_HI = 9;
  localparam int unsigned PD_LO = 8;
  localparam int unsigned MASK_HI = 7;
  localparam int unsigned MASK_LO = 0;
  localparam int unsigned CLR_HI = 1;
  localparam int unsigned CLR_LO = 0;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CODE_W = 12;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [3:0] CMD_WRITE_IN = 4'h0;
  localparam logic [3:0] CMD_UPDATE_N = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPD_N = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h3;
  localparam logic [3:0] CMD_PWRDN = 4'h4;
  localparam logic [3:0] CMD_CLR_CODE = 4'h5;
  localparam logic [3:0] CMD_OVERRIDE = 4'h6;
  localparam logic [3:0] ADDR_ALL = 4'hF;

  // ****************************************
  // clear codes and reset values
  // ****************************************
  localparam logic [1:0] CLR_ZERO = 2'h0;
  localparam logic [1:0] CLR_MID = 2'h1;
  localparam logic [1:0] CLR_FULL = 2'h2;
  localparam logic [1:0] CLR_NOP = 2'h3;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] CODE_FULL = 12'hFFF;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_TRISTATE = 2'h3;
  localparam logic [7:0] OVERRIDE_RST = 8'h00;
  localparam logic [1:0] CLR_SEL_RST = 2'h0;
  // idle levels of sclk, sync, data, load, clear
  localparam logic [4:0] PIN_IDLE = 5'h1B;

  // ****************************************
  // frame receiver states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b11,
    ST_ABORT = 2'b10
  } duc_state_t;
endpackage : duc_pkg

// ---- rtl/duc_sync2.sv ----
// two-flop synchroniser for asynchronous pins
// assumes the pins idle at the given reset level
`timescale 1ns/1ps
`default_nettype none
module duc_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule : duc_sync2
`default_nettype wire

// ---- rtl/duc_update_ctrl.sv ----
// dac command decode and load-update control for one group of eight channels
// assumes pins are asynchronous to ref_clk and the serial clock is far slower
`timescale 1ns/1ps
`default_nettype none
module duc_update_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial link
  input wire logic dac_serial_clock,
  input wire logic dac_frame_sync_n,
  input wire logic dac_serial_data,
  // control pins
  input wire logic load_update_n,
  input wire logic async_clear_n,
  // channel state
  output logic [7:0][11:0] inputCode,
  output logic [7:0][11:0] dacCode,
  output logic [7:0][1:0] pwrdnMode,
  output logic clearActive
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pinsS;
  logic sclkS;
  logic syncNS;
  logic dinS;
  logic ldacNS;
  logic clrNS;

  duc_sync2 #(
    .W(5),
    .INIT(duc_pkg::PIN_IDLE)
  ) uSync (
    .clk(ref_clk),
    .rstN(reset_n),
    .d({dac_serial_clock, dac_frame_sync_n, dac_serial_data, load_update_n, async_clear_n}),
    .q(pinsS)
  );

  assign {sclkS, syncNS, dinS, ldacNS, clrNS} = pinsS;

  // ****************************************
  // edge detection
  // ****************************************
  logic sclkPrev_q;
  logic syncPrev_q;
  logic ldacPrev_q;
  logic clrPrev_q;
  logic sclkFall;
  logic syncRise;
  logic ldacFall;
  logic clrFall;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkPrev_q <= 1'b1;
      syncPrev_q <= 1'b1;
      ldacPrev_q <= 1'b1;
      clrPrev_q <= 1'b1;
    end else begin
      sclkPrev_q <= sclkS;
      syncPrev_q <= syncNS;
      ldacPrev_q <= ldacNS;
      clrPrev_q <= clrNS;
    end
  end

  assign sclkFall = sclkPrev_q & ~sclkS;
  assign syncRise = ~syncPrev_q & syncNS;
  assign ldacFall = ldacPrev_q & ~ldacNS;
  assign clrFall = clrPrev_q & ~clrNS;

  // ****************************************
  // frame receiver
  // ****************************************
  duc_pkg::duc_state_t state_q;
  duc_pkg::duc_state_t state_d;
  logic [5:0] bitCnt_q;
  logic [5:0] bitCnt_d;
  logic [31:0] shift_q;
  logic [31:0] shift_d;
  logic [31:0] frameWord;
  logic exec;

  assign frameWord = {shift_q[30:0], dinS};

  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    exec = 1'b0;
    case (state_q)
      duc_pkg::ST_IDLE: begin
        bitCnt_d = '0;
        if (!syncNS) begin
          state_d = duc_pkg::ST_SHIFT;
        end
      end
      duc_pkg::ST_SHIFT: begin
        if (syncNS) begin
          state_d = duc_pkg::ST_IDLE;
          bitCnt_d = '0;
          shift_d = '0;
        end else if (sclkFall) begin
          shift_d = frameWord;
          bitCnt_d = bitCnt_q + 6'h01;
          if (bitCnt_q == duc_pkg::LAST_BIT) begin
            exec = 1'b1;
            state_d = duc_pkg::ST_DONE;
          end
        end
      end
      duc_pkg::ST_DONE, duc_pkg::ST_ABORT: begin
        if (syncNS) begin
          state_d = duc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = duc_pkg::ST_IDLE;
      end
    endcase
    if (clrFall) begin
      exec = 1'b0;
      bitCnt_d = '0;
      shift_d = '0;
      state_d = syncNS ? duc_pkg::ST_IDLE : duc_pkg::ST_ABORT;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= duc_pkg::ST_IDLE;
      bitCnt_q <= '0;
      shift_q <= '0;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
    end
  end

  // ****************************************
  // frame fields
  // ****************************************
  logic [3:0] cmd;
  logic [3:0] addr;
  logic [11:0] data;
  logic [1:0] pdBits;
  logic [7:0] chMask;
  logic [1:0] clrBits;
  logic isWrite;
  logic [7:0] addrSel;

  assign cmd = frameWord[duc_pkg::CMD_HI:duc_pkg::CMD_LO];
  assign addr = frameWord[duc_pkg::ADDR_HI:duc_pkg::ADDR_LO];
  assign data = frameWord[duc_pkg::DATA_HI:duc_pkg::DATA_LO];
  assign pdBits = frameWord[duc_pkg::PD_HI:duc_pkg::PD_LO];
  assign chMask = frameWord[duc_pkg::MASK_HI:duc_pkg::MASK_LO];
  assign clrBits = frameWord[duc_pkg::CLR_HI:duc_pkg::CLR_LO];
  assign isWrite = (cmd == duc_pkg::CMD_WRITE_IN) || (cmd == duc_pkg::CMD_WRITE_UPD_N)
                   || (cmd == duc_pkg::CMD_WRITE_UPD_ALL);

  always_comb begin
    for (int i = 0; i < duc_pkg::NUM_CH; i++) begin
      addrSel[i] = (addr == duc_pkg::ADDR_ALL) || (addr == 4'(i));
    end
  end

  // ****************************************
  // channel registers
  // ****************************************
  logic [7:0][11:0] inReg_q;
  logic [7:0][11:0] inReg_d;
  logic [7:0][11:0] dacReg_q;
  logic [7:0][11:0] dacReg_d;
  logic [7:0][1:0] pdMode_q;
  logic [7:0][1:0] pdMode_d;
  logic [7:0] override_q;
  logic [7:0] override_d;
  logic [1:0] clrSel_q;
  logic [1:0] clrSel_d;
  logic clearMode_q;
  logic clearMode_d;
  logic [11:0] clrCode;

  always_comb begin
    case (clrSel_q)
      duc_pkg::CLR_ZERO: clrCode = duc_pkg::CODE_ZERO;
      duc_pkg::CLR_MID: clrCode = duc_pkg::CODE_MID;
      duc_pkg::CLR_FULL: clrCode = duc_pkg::CODE_FULL;
      default: clrCode = duc_pkg::CODE_ZERO;
    endcase
  end

  always_comb begin
    inReg_d = inReg_q;
    dacReg_d = dacReg_q;
    pdMode_d = pdMode_q;
    override_d = override_q;
    clrSel_d = clrSel_q;
    clearMode_d = clearMode_q;
    if (exec) begin
      case (cmd)
        duc_pkg::CMD_WRITE_IN, duc_pkg::CMD_WRITE_UPD_N, duc_pkg::CMD_WRITE_UPD_ALL: begin
          for (int i = 0; i < duc_pkg::NUM_CH; i++) begin
            if (addrSel[i]) begin
              inReg_d[i] = data;
              if (!ldacNS || override_q[i] || (cmd == duc_pkg::CMD_WRITE_UPD_N)) begin
                dacReg_d[i] = data;
              end
            end
          end
          if (cmd == duc_pkg::CMD_WRITE_UPD_ALL) begin
            dacReg_d = inReg_d;
          end
          clearMode_d = 1'b0;
        end
        duc_pkg::CMD_UPDATE_N: begin
          for (int i = 0; i < duc_pkg::NUM_CH; i++) begin
            if (addrSel[i]) begin
              dacReg_d[i] = inReg_q[i];
            end
          end
        end
        duc_pkg::CMD_PWRDN: begin
          for (int i = 0; i < duc_pkg::NUM_CH; i++) begin
            if (chMask[i]) begin
              pdMode_d[i] = pdBits;
            end
          end
        end
        duc_pkg::CMD_CLR_CODE: begin
          clrSel_d = clrBits;
        end
        duc_pkg::CMD_OVERRIDE: begin
          override_d = chMask;
        end
        default: begin
        end
      endcase
    end
    if (ldacFall) begin
      dacReg_d = inReg_d;
    end
    if (clrFall && (clrSel_q != duc_pkg::CLR_NOP)) begin
      for (int i = 0; i < duc_pkg::NUM_CH; i++) begin
        inReg_d[i] = clrCode;
        dacReg_d[i] = clrCode;
      end
      clearMode_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      inReg_q <= '0;
      dacReg_q <= '0;
      pdMode_q <= '0;
      override_q <= duc_pkg::OVERRIDE_RST;
      clrSel_q <= duc_pkg::CLR_SEL_RST;
      clearMode_q <= 1'b0;
    end else begin
      inReg_q <= inReg_d;
      dacReg_q <= dacReg_d;
      pdMode_q <= pdMode_d;
      override_q <= override_d;
      clrSel_q <= clrSel_d;
      clearMode_q <= clearMode_d;
    end
  end

  assign inputCode = inReg_q;
  assign dacCode = dacReg_q;
  assign pwrdnMode = pdMode_q;
  assign clearActive = clearMode_q;

  // ****************************************
  // assertions
  // ****************************************
  logic [7:0][1:0] pdKeep;

  always_comb begin
    for (int i = 0; i < duc_pkg::NUM_CH; i++) begin
      pdKeep[i] = chMask[i] ? 2'h0 : 2'h3;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_frame_discard: assert property (
    (state_q == duc_pkg::ST_SHIFT) && syncNS && !clrFall |=> state_q == duc_pkg::ST_IDLE && $stable(pdMode_q)
      && $stable(inReg_q) && $stable(override_q)) else $error("short frame changed state");
  a_exec_count: assert property (
    exec |-> bitCnt_q == duc_pkg::LAST_BIT && sclkFall && !syncNS) else $error("frame ended off count");
  a_pd_mask: assert property (
    exec && cmd == duc_pkg::CMD_PWRDN |=> (pdMode_q & $past(pdKeep)) == ($past(pdMode_q) & $past(pdKeep))
      && $stable(dacReg_q)) else $error("unmasked channel mode changed");
  a_clear_sel: assert property (
    exec && cmd == duc_pkg::CMD_CLR_CODE |=> clrSel_q == $past(clrBits)) else $error("clear select not loaded");
  a_clear_mid: assert property (
    clrFall && clrSel_q == duc_pkg::CLR_MID |=> dacReg_q[0] == duc_pkg::CODE_MID && inReg_q[7] == duc_pkg::CODE_MID)
    else $error("clear mid code wrong");
  a_clear_nop: assert property (
    clrFall && clrSel_q == duc_pkg::CLR_NOP && !ldacFall |=> $stable(inReg_q) && $stable(dacReg_q))
    else $error("clear nop altered registers");
  a_async_copy: assert property (
    ldacFall && !clrFall && !exec |=> dacReg_q == $past(inReg_q)) else $error("load fall did not copy");
  a_sw_update: assert property (
    exec && cmd == duc_pkg::CMD_WRITE_UPD_ALL && !clrFall |=> dacReg_q == inReg_q) else $error("software update missed");
  a_override_load: assert property (
    exec && cmd == duc_pkg::CMD_OVERRIDE |=> override_q == $past(chMask)) else $error("override not loaded");
  a_hold_write: assert property (
    exec && cmd == duc_pkg::CMD_WRITE_IN && addr == 4'h0 && ldacNS && !override_q[0] && !ldacFall
      |=> dacReg_q[0] == $past(dacReg_q[0]) && inReg_q[0] == $past(data)) else $error("held channel updated");
  a_clear_abort: assert property (
    clrFall |=> !$past(exec) && bitCnt_q == 6'h00) else $error("clear did not abort frame");

  c_write_frame: cover property (exec && isWrite);
  c_short_frame: cover property ((state_q == duc_pkg::ST_SHIFT) && syncNS && bitCnt_q != 6'h00);
  c_clear_event: cover property (clrFall && clrSel_q != duc_pkg::CLR_NOP);
  c_async_load: cover property (ldacFall);
endmodule : duc_update_ctrl
`default_nettype wire

// ---- testbench/duc_host_model.sv ----
// host controller model driving the dac serial link
// assumes the bench calls send_frame and nothing else drives these pins
`timescale 1ns/1ps
`default_nettype none
module duc_host_model (
  // serial link
  output var logic serClk,
  output var logic frameSyncN,
  output var logic serData
);
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    serClk = 1'b1;
    frameSyncN = 1'b1;
    serData = 1'b0;
  end

  // ****************************************
  // frame driver
  // ****************************************
  task automatic send_frame(input logic [31:0] word, input int nBits);
    frameSyncN = 1'b0;
    #40;
    for (int i = 0; i < nBits; i++) begin
      serData = word[31 - i];
      #40;
      serClk = 1'b0;
      #40;
      serClk = 1'b1;
    end
    #40;
    frameSyncN = 1'b1;
    // released line shows no stale bit
    serData = ~serData;
    #80;
  endtask : send_frame
endmodule : duc_host_model
`default_nettype wire

// ---- testbench/test_duc_update_ctrl.sv ----
// self-checking bench for the dac update control block
// assumes the host model drives the link with an 80 ns serial clock
`timescale 1ns/1ps
`default_nettype none
module test_duc_update_ctrl;
  // ****************************************
  // signals
  // ****************************************
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic serClk;
  logic frameSyncN;
  logic serData;
  logic loadN = 1'b1;
  logic clearN = 1'b1;
  logic [7:0][11:0] inputCode;
  logic [7:0][11:0] dacCode;
  logic [7:0][1:0] pwrdnMode;
  logic clearActive;
  logic [11:0] expIn [8];
  logic [11:0] expDac [8];
  logic [1:0] expPd [8];
  int errors = 0;
  int total_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  duc_host_model i_duc_host_model (.serClk(serClk), .frameSyncN(frameSyncN), .serData(serData));
  duc_update_ctrl i_duc_update_ctrl (
    .ref_clk(ref_clk), .reset_n(reset_n), .dac_serial_clock(serClk),
    .dac_frame_sync_n(frameSyncN), .dac_serial_data(serData), .load_update_n(loadN),
    .async_clear_n(clearN), .inputCode(inputCode), .dacCode(dacCode),
    .pwrdnMode(pwrdnMode), .clearActive(clearActive)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic end_of_test();
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t code %h expected %h", $time, got, exp);
    end
  endtask : chk_code

  task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t mode %h expected %h", $time, got, exp);
    end
  endtask : chk_mode

  task automatic check_all();
    for (int i = 0; i < 8; i++) begin
      chk_code(inputCode[i], expIn[i]);
      chk_code(dacCode[i], expDac[i]);
      chk_mode(pwrdnMode[i], expPd[i]);
    end
  endtask : check_all

  // junk in the top nibble
  function automatic logic [31:0] fr(input logic [3:0] c, input logic [3:0] a, input logic [19:0] d);
    return {4'hA, c, a, d};
  endfunction : fr

  task automatic send(input logic [31:0] w, input int n);
    i_duc_host_model.send_frame(w, n);
    repeat (8) @(negedge ref_clk);
  endtask : send

  task automatic set_load(input logic v);
    @(negedge ref_clk);
    loadN = v;
    repeat (8) @(negedge ref_clk);
  endtask : set_load

  task automatic set_clear(input logic v);
    @(negedge ref_clk);
    clearN = v;
    repeat (8) @(negedge ref_clk);
  endtask : set_clear

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_async();
    send(fr(4'h0, 4'h2, 20'h5A53C), 32);
    expIn[2] = 12'h5A5;
    check_all();
    set_load(1'b0);
    foreach (expDac[i]) expDac[i] = expIn[i];
    check_all();
    set_load(1'b1);
  endtask : t_async

  task automatic t_sync();
    set_load(1'b0);
    send(fr(4'h0, 4'h3, 20'h3C3FF), 32);
    expIn[3] = 12'h3C3;
    expDac[3] = 12'h3C3;
    check_all();
    send(fr(4'h0, 4'h1, 20'h77700), 31);
    check_all();
    set_load(1'b1);
  endtask : t_sync

  task automatic t_soft();
    send(fr(4'h0, 4'h0, 20'h11100), 32);
    send(fr(4'h3, 4'h1, 20'h22200), 32);
    expIn[0] = 12'h111;
    expIn[1] = 12'h222;
    foreach (expDac[i]) expDac[i] = expIn[i];
    check_all();
  endtask : t_soft

  task automatic t_override();
    send(fr(4'h6, 4'h5, 20'hFFF10), 32);
    send(fr(4'h0, 4'h4, 20'h44400), 32);
    send(fr(4'h0, 4'h5, 20'h55500), 32);
    expIn[4] = 12'h444;
    expIn[5] = 12'h555;
    expDac[4] = 12'h444;
    check_all();
    send(fr(4'h6, 4'h0, 20'h00000), 32);
  endtask : t_override

  task automatic t_chan();
    send(fr(4'h1, 4'h5, 20'h00000), 32);
    expDac[5] = expIn[5];
    send(fr(4'h2, 4'h6, 20'h66600), 32);
    expIn[6] = 12'h666;
    expDac[6] = 12'h666;
    check_all();
    send(fr(4'h0, 4'hF, 20'h12300), 32);
    foreach (expIn[i]) expIn[i] = 12'h123;
    check_all();
  endtask : t_chan

  task automatic t_pwrdn();
    logic [1:0] modes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [7:0] masks [4] = '{8'h81, 8'h42, 8'h24, 8'hFF};
    for (int k = 0; k < 4; k++) begin
      send(fr(4'h4, 4'h3, {10'h2AA, modes[k], masks[k]}), 32);
      for (int i = 0; i < 8; i++) if (masks[k][i]) expPd[i] = modes[k];
      check_all();
    end
  endtask : t_pwrdn

  task automatic t_clear();
    logic [11:0] codes [4] = '{12'h000, 12'h800, 12'hFFF, 12'h000};
    for (int s = 3; s >= 0; s--) begin
      send(fr(4'h5, 4'h7, {18'h2AAAA, s[1:0]}), 32);
      fork
        i_duc_host_model.send_frame(fr(4'h0, 4'h6, 20'h6A600), 32);
        begin
          repeat (160) @(negedge ref_clk);
          clearN = 1'b0;
        end
      join
      repeat (8) @(negedge ref_clk);
      if (s != 3) begin
        foreach (expIn[i]) expIn[i] = codes[s];
        foreach (expDac[i]) expDac[i] = codes[s];
      end
      chk_mode({1'b0, clearActive}, {1'b0, s != 3});
      check_all();
      set_clear(1'b1);
      send(fr(4'h0, 4'h0, 20'h0F000), 32);
      expIn[0] = 12'h0F0;
      chk_mode({1'b0, clearActive}, 2'h0);
      check_all();
    end
  endtask : t_clear

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    foreach (expIn[i]) begin
      expIn[i] = 12'h000;
      expDac[i] = 12'h000;
      expPd[i] = 2'h0;
    end
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check_all();
    chk_mode({1'b0, clearActive}, 2'h0);
    t_async();
    t_sync();
    t_soft();
    t_override();
    t_chan();
    t_pwrdn();
    t_clear();
    end_of_test();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
endmodule : test_duc_update_ctrl
`default_nettype wire
